//--- core/cdr_top.sv
// diagnostic record of the single channel counter function module
`timescale 1ns/1ps
module cdr_top #(
   parameter logic [6:0] CHANNEL_KIND_CODE = 7'h2a // arbitrary value
) (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        module_failure,
   input  wire logic        external_error,
   input  wire logic        output_overload,
   input  wire logic        diag_buffer_overflow,
   input  wire logic [4:0]  lost_event,
   input  wire logic        rd_req,
   input  wire logic [7:0]  rd_index,
   input  wire logic        wr_req,
   output logic [7:0]       rd_data,
   output logic             rd_ack,
   output logic             wr_ack,
   output logic             diag_active
);
   logic                reset_meta_n;
   logic                reset_sync_n;
   logic [31:0]         us_count;
   cdr_pkg::cdr_state_t state;
   cdr_pkg::cdr_state_t next_state;
   logic                buf_ovf;
   logic                next_buf_ovf;
   logic                irq_lost;
   logic                next_irq_lost;
   logic [4:0]          cause;
   logic [4:0]          next_cause;
   logic                fail_q;
   logic                ext_q;
   logic                ovl_q;
   logic [7:0]          general;
   logic [7:0]          next_general;
   logic [7:0]          second;
   logic [7:0]          next_second;
   logic [31:0]         stamp;
   logic [31:0]         next_stamp;
   logic                clr_sticky;
   logic                any_cause;

   cdr_rec_if rec ();

   // reset release through two flops
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         reset_meta_n <= 1'b0;
         reset_sync_n <= 1'b0;
      end else begin
         reset_meta_n <= 1'b1;
         reset_sync_n <= reset_meta_n;
      end
   end

   cdr_ticker u_ticker (
      .sys_clk  (sys_clk),
      .reset_n  (reset_sync_n),
      .us_count (us_count)
   );

   // reading the second diagnostic byte acknowledges the latched events
   assign clr_sticky = rd_req && (rd_index == cdr_pkg::IDX_SECOND);

   always_comb begin
      next_buf_ovf  = (buf_ovf && !clr_sticky) || diag_buffer_overflow; // R7
      next_irq_lost = irq_lost && !clr_sticky;
      next_cause    = clr_sticky ? cdr_pkg::LOST_NONE : cause;
      // channel events only stored while no diagnostic is pending
      if (state == cdr_pkg::CDR_IDLE && lost_event != cdr_pkg::LOST_NONE) begin // R16
         next_irq_lost = 1'b1; // R8
         next_cause    = lost_event; // R13
      end
      any_cause = module_failure || external_error || output_overload
                  || next_buf_ovf || next_irq_lost;
      next_state = state;
      case (state)
         cdr_pkg::CDR_IDLE: begin
            if (any_cause) begin
               next_state = cdr_pkg::CDR_ACTIVE;
            end
         end
         cdr_pkg::CDR_ACTIVE: begin
            if (!any_cause) begin
               next_state = cdr_pkg::CDR_IDLE; // R16
            end
         end
         default: next_state = cdr_pkg::CDR_IDLE;
      endcase
      next_stamp = stamp;
      if (state == cdr_pkg::CDR_IDLE && next_state == cdr_pkg::CDR_ACTIVE) begin
         next_stamp = us_count; // R14
      end
   end

   always_comb begin
      next_general                        = cdr_pkg::BYTE_ZERO; // R17
      next_general[cdr_pkg::GEN_MOD_FAIL] = module_failure; // R1
      next_general[cdr_pkg::GEN_EXT_ERR]  = external_error; // R2
      next_general[cdr_pkg::GEN_CH_ERR]   = next_cause != cdr_pkg::LOST_NONE; // R3
      next_general[cdr_pkg::GEN_OVERLOAD] = output_overload; // R4
      next_second                         = cdr_pkg::BYTE_ZERO; // R17
      next_second[cdr_pkg::SEC_BUF_OVF]   = next_buf_ovf; // R7
      next_second[cdr_pkg::SEC_IRQ_LOST]  = next_irq_lost; // R8
   end

   always_ff @(posedge sys_clk or negedge reset_sync_n) begin
      if (!reset_sync_n) begin
         state       <= cdr_pkg::CDR_IDLE;
         buf_ovf     <= 1'b0;
         irq_lost    <= 1'b0;
         cause       <= cdr_pkg::LOST_NONE;
         general     <= cdr_pkg::BYTE_ZERO;
         second      <= cdr_pkg::BYTE_ZERO;
         stamp       <= cdr_pkg::STAMP_ZERO;
         fail_q      <= 1'b0;
         ext_q       <= 1'b0;
         ovl_q       <= 1'b0;
         diag_active <= 1'b0;
      end else begin
         state       <= next_state;
         buf_ovf     <= next_buf_ovf;
         irq_lost    <= next_irq_lost;
         cause       <= next_cause;
         general     <= next_general;
         second      <= next_second;
         stamp       <= next_stamp;
         fail_q      <= module_failure;
         ext_q       <= external_error;
         ovl_q       <= output_overload;
         diag_active <= next_state == cdr_pkg::CDR_ACTIVE;
      end
   end

   assign rec.general = general;
   assign rec.second  = second;
   assign rec.cause   = cause;
   assign rec.stamp   = stamp;

   cdr_reader #(
      .CHANNEL_KIND_CODE (CHANNEL_KIND_CODE)
   ) u_reader (
      .sys_clk  (sys_clk),
      .reset_n  (reset_sync_n),
      .rec      (rec),
      .rd_req   (rd_req),
      .rd_index (rd_index),
      .wr_req   (wr_req),
      .rd_data  (rd_data),
      .rd_ack   (rd_ack),
      .wr_ack   (wr_ack)
   );

   sequence diag_coming;
      state == cdr_pkg::CDR_IDLE ##1 state == cdr_pkg::CDR_ACTIVE;
   endsequence

   sequence lost_taken;
      state == cdr_pkg::CDR_IDLE && lost_event != 5'h00;
   endsequence

   mod_fail_a: assert property (@(posedge sys_clk) disable iff (!reset_sync_n) // R1
      module_failure |=> general[0] && diag_active)
      else $error("module failure not reported");
   ext_err_a: assert property (@(posedge sys_clk) disable iff (!reset_sync_n) // R2
      general[2] == ext_q && general[1] == 1'b0)
      else $error("external error bit wrong");
   chan_err_a: assert property (@(posedge sys_clk) disable iff (!reset_sync_n) // R3
      general[3] == (cause != 5'h00))
      else $error("channel error bit disagrees with cause");
   overload_a: assert property (@(posedge sys_clk) disable iff (!reset_sync_n) // R4
      general[4] == ovl_q && general[0] == fail_q)
      else $error("overload or failure bit wrong");
   buf_ovf_a: assert property (@(posedge sys_clk) disable iff (!reset_sync_n) // R7
      diag_buffer_overflow |=> second[3])
      else $error("buffer overflow lost");
   lost_set_a: assert property (@(posedge sys_clk) disable iff (!reset_sync_n) // R8
      lost_taken |=> second[6] && cause == $past(lost_event))
      else $error("lost interrupt not recorded");
   lost_drop_a: assert property (@(posedge sys_clk) disable iff (!reset_sync_n) // R16
      state == cdr_pkg::CDR_ACTIVE && !clr_sticky |=> cause == $past(cause))
      else $error("channel event stored while diagnostic pending");
   stamp_take_a: assert property (@(posedge sys_clk) disable iff (!reset_sync_n) // R14
      diag_coming |-> stamp == $past(us_count))
      else $error("timestamp not captured on entry");
   stamp_keep_a: assert property (@(posedge sys_clk) disable iff (!reset_sync_n) // R14
      state == cdr_pkg::CDR_ACTIVE ##1 state == cdr_pkg::CDR_ACTIVE |-> $stable(stamp))
      else $error("timestamp changed during diagnostic");
   diag_going_a: assert property (@(posedge sys_clk) disable iff (!reset_sync_n) // R16
      state == cdr_pkg::CDR_ACTIVE && general == 8'h00 && second == 8'h00
      && !module_failure && !external_error && !output_overload
      && !diag_buffer_overflow |=> !diag_active)
      else $error("diagnostic not withdrawn");
   rsvd_bits_a: assert property (@(posedge sys_clk) disable iff (!reset_sync_n) // R17
      general[7:5] == 3'h0 && second[7] == 1'b0 && second[5:4] == 2'h0
      && second[2:0] == 3'h0)
      else $error("reserved bit set");
   write_none_a: assert property (@(posedge sys_clk) disable iff (!reset_sync_n) // R17
      wr_req && !rd_req && !diag_buffer_overflow && lost_event == 5'h00
      |=> $stable(cause) && second == $past(second))
      else $error("write altered the record");
endmodule

//--- core/cdr_pkg.sv
// constants, record layout and state type of the counter diagnostic record
// Function
// [R1] general diagnostic bit 0 set while a module failure is present
// [R2] general diagnostic bit 2 set on external error; bits 1, 7..5 reserved
// [R3] general diagnostic bit 3 set while any channel reports an error
// [R4] general diagnostic bit 4 set on overload at the module output
// [R5] module information bits 3..0 hold class 1000b, function module; 7..5 reserved
// [R6] module information bit 4 set: channel-specific diagnostic data present
// [R7] second diagnostic bit 3 set on internal diagnostics buffer overflow
// [R8] second diagnostic bit 6 set when a process interrupt was lost
// [R9] channel kind byte holds fixed seven-bit counter channel code, bit 7 zero
// [R10] diagnostic bits per channel byte always reads 08h
// [R11] channel count byte always reads 01h
// [R12] channel group error bit 0 set on error in channel group 0
// [R13] lost interrupt cause byte flags which event's process interrupt was lost
// [R14] timestamp field captures the microsecond ticker when the diagnostic comes in
// [R15] ticker starts at zero from power-up, counts microseconds, wraps after 2^32-1
// [R16] diagnostic withdraws when cause goes; channel events meanwhile are dropped
// [R17] reserved bits and bytes read zero; writes to the record do nothing
// [R18] a prescaler from the module clock makes exactly one tick per microsecond
package cdr_pkg;
   // clock and ticker timing
   localparam int unsigned CLK_PERIOD_NS  = 25;
   localparam int unsigned TICK_PERIOD_NS = 1000;
   localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned PRESC_W        = 6;
   localparam logic [5:0]  PRESC_LAST     = 6'(TICK_CYCLES - 1);
   localparam logic [5:0]  PRESC_ZERO     = 6'h00;
   localparam int unsigned STAMP_W        = 32;
   localparam logic [31:0] STAMP_ZERO     = 32'h0000_0000;
   localparam logic [31:0] STAMP_ONE      = 32'h0000_0001;

   // general diagnostic field positions
   localparam int unsigned GEN_MOD_FAIL = 0;
   localparam int unsigned GEN_EXT_ERR  = 2;
   localparam int unsigned GEN_CH_ERR   = 3;
   localparam int unsigned GEN_OVERLOAD = 4;

   // module information layout
   localparam logic [3:0]  CLASS_FUNCTION = 4'h8;
   localparam int unsigned MODINFO_CHINFO = 4;

   // second diagnostic field positions
   localparam int unsigned SEC_BUF_OVF  = 3;
   localparam int unsigned SEC_IRQ_LOST = 6;

   // channel group error and lost interrupt cause layout
   localparam int unsigned CHGRP_ERR0     = 0;
   localparam int unsigned LOST_W         = 5;
   localparam int unsigned LOST_GATE_OPEN = 0;
   localparam int unsigned LOST_GATE_SHUT = 1;
   localparam int unsigned LOST_LIMIT     = 2;
   localparam int unsigned LOST_COMPARE   = 3;
   localparam int unsigned LOST_LATCH     = 4;
   localparam logic [4:0]  LOST_NONE      = 5'h00;

   // fixed descriptor values
   localparam logic [7:0] DIAG_BITS_VALUE     = 8'h08;
   localparam logic [7:0] CHANNEL_COUNT_VALUE = 8'h01;
   localparam logic [7:0] BYTE_ZERO           = 8'h00;

   // record byte indexes
   localparam logic [7:0] IDX_GENERAL   = 8'h02;
   localparam logic [7:0] IDX_MODINFO   = 8'h03;
   localparam logic [7:0] IDX_RSVD_C    = 8'h04;
   localparam logic [7:0] IDX_SECOND    = 8'h05;
   localparam logic [7:0] IDX_CH_KIND   = 8'h06;
   localparam logic [7:0] IDX_DIAG_BITS = 8'h07;
   localparam logic [7:0] IDX_CH_COUNT  = 8'h08;
   localparam logic [7:0] IDX_CHGRP_ERR = 8'h09;
   localparam logic [7:0] IDX_CAUSE     = 8'h0a;
   localparam logic [7:0] IDX_STAMP0    = 8'h13;
   localparam logic [7:0] IDX_STAMP1    = 8'h14;
   localparam logic [7:0] IDX_STAMP2    = 8'h15;
   localparam logic [7:0] IDX_STAMP3    = 8'h16;

   typedef enum logic [0:0] {
      CDR_IDLE,
      CDR_ACTIVE
   } cdr_state_t;
endpackage

//--- core/cdr_rec_if.sv
// carrier of the live diagnostic record between the top and its reader
`timescale 1ns/1ps
interface cdr_rec_if;
   logic [7:0]  general;
   logic [7:0]  second;
   logic [4:0]  cause;
   logic [31:0] stamp;

   modport producer (output general, output second, output cause, output stamp);
   modport consumer (input general, input second, input cause, input stamp);
endinterface

//--- core/cdr_ticker.sv
// free running microsecond ticker with its clock prescaler
`timescale 1ns/1ps
module cdr_ticker (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   output logic [31:0]      us_count
);
   logic [5:0]  presc;
   logic [5:0]  next_presc;
   logic [31:0] next_us_count;

   always_comb begin
      next_presc    = presc + 6'h01;
      next_us_count = us_count;
      if (presc == cdr_pkg::PRESC_LAST) begin // R18
         next_presc    = cdr_pkg::PRESC_ZERO;
         next_us_count = us_count + cdr_pkg::STAMP_ONE; // R15
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         presc    <= cdr_pkg::PRESC_ZERO;
         us_count <= cdr_pkg::STAMP_ZERO;
      end else begin
         presc    <= next_presc;
         us_count <= next_us_count;
      end
   end

   presc_range_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R18
      presc <= cdr_pkg::PRESC_LAST)
      else $error("prescaler left its range");
   tick_step_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R15
      presc == cdr_pkg::PRESC_LAST |=> us_count == $past(us_count) + cdr_pkg::STAMP_ONE)
      else $error("ticker missed its microsecond step");
   tick_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R18
      presc != cdr_pkg::PRESC_LAST |=> $stable(us_count))
      else $error("ticker moved between microseconds");
endmodule

//--- core/cdr_reader.sv
// byte read port of the diagnostic record with fixed descriptor bytes
`timescale 1ns/1ps
module cdr_reader #(
   parameter logic [6:0] CHANNEL_KIND_CODE = 7'h2a
) (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   cdr_rec_if.consumer      rec,
   input  wire logic        rd_req,
   input  wire logic [7:0]  rd_index,
   input  wire logic        wr_req,
   output logic [7:0]       rd_data,
   output logic             rd_ack,
   output logic             wr_ack
);
   logic [7:0] next_rd_data;
   logic [7:0] modinfo;

   always_comb begin
      modinfo                          = {4'h0, cdr_pkg::CLASS_FUNCTION}; // R5
      modinfo[cdr_pkg::MODINFO_CHINFO] = 1'b1; // R6
      next_rd_data                     = cdr_pkg::BYTE_ZERO; // R17
      if (rd_req) begin
         case (rd_index)
            cdr_pkg::IDX_GENERAL:   next_rd_data = rec.general;
            cdr_pkg::IDX_MODINFO:   next_rd_data = modinfo;
            cdr_pkg::IDX_SECOND:    next_rd_data = rec.second;
            cdr_pkg::IDX_CH_KIND:   next_rd_data = {1'b0, CHANNEL_KIND_CODE}; // R9
            cdr_pkg::IDX_DIAG_BITS: next_rd_data = cdr_pkg::DIAG_BITS_VALUE; // R10
            cdr_pkg::IDX_CH_COUNT:  next_rd_data = cdr_pkg::CHANNEL_COUNT_VALUE; // R11
            cdr_pkg::IDX_CHGRP_ERR: next_rd_data = {7'h00, |rec.cause}; // R12
            cdr_pkg::IDX_CAUSE:     next_rd_data = {3'h0, rec.cause}; // R13
            cdr_pkg::IDX_STAMP0:    next_rd_data = rec.stamp[31:24];
            cdr_pkg::IDX_STAMP1:    next_rd_data = rec.stamp[23:16];
            cdr_pkg::IDX_STAMP2:    next_rd_data = rec.stamp[15:8];
            cdr_pkg::IDX_STAMP3:    next_rd_data = rec.stamp[7:0];
            default:                next_rd_data = cdr_pkg::BYTE_ZERO; // R17
         endcase
      end
   end

   // writes are acknowledged but never touch the record
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= cdr_pkg::BYTE_ZERO;
         rd_ack  <= 1'b0;
         wr_ack  <= 1'b0;
      end else begin
         rd_data <= next_rd_data;
         rd_ack  <= rd_req;
         wr_ack  <= wr_req; // R17
      end
   end

   kind_byte_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R9
      rd_req && rd_index == cdr_pkg::IDX_CH_KIND |=> rd_ack && rd_data == {1'b0, CHANNEL_KIND_CODE})
      else $error("channel kind byte wrong");
   bits_byte_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R10
      rd_req && rd_index == cdr_pkg::IDX_DIAG_BITS |=> rd_data == 8'h08)
      else $error("diagnostic bit count not 08h");
   count_byte_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R11
      rd_req && rd_index == cdr_pkg::IDX_CH_COUNT |=> rd_data == 8'h01)
      else $error("channel count not 01h");
   modinfo_byte_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R5
      rd_req && rd_index == cdr_pkg::IDX_MODINFO |=> rd_data == 8'h18)
      else $error("module information byte wrong");
   rsvd_bytes_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R17
      rd_req && rd_index > cdr_pkg::IDX_CAUSE && rd_index < cdr_pkg::IDX_STAMP0
      |=> rd_data == 8'h00)
      else $error("reserved byte not zero");
   read_answer_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // R17
      rd_req |=> rd_ack ##1 !rd_ack || $past(rd_req))
      else $error("read answer timing wrong");
endmodule

//--- test/cdr_host.sv
// host side model that reads and writes record bytes one request at a time
`timescale 1ns/1ps
module cdr_host (
   input  wire logic        sys_clk,
   input  wire logic [7:0]  rd_data,
   input  wire logic        rd_ack,
   input  wire logic        wr_ack,
   output logic             rd_req,
   output logic [7:0]       rd_index,
   output logic             wr_req
);
   initial begin
      rd_req   = 1'b0;
      rd_index = 8'h00;
      wr_req   = 1'b0;
   end

   // index shows the inverse once released, so a stale value cannot match
   task automatic read_byte(input logic [7:0] idx, output logic [7:0] data, output logic ack);
      @(posedge sys_clk);
      rd_req   <= 1'b1;
      rd_index <= idx;
      @(posedge sys_clk);
      rd_req   <= 1'b0;
      rd_index <= ~idx;
      // answer stands for one cycle; take it at the edge where ack is seen high
      @(posedge sys_clk);
      data = rd_data;
      ack  = rd_ack;
   endtask

   task automatic write_byte(output logic ack);
      @(posedge sys_clk);
      wr_req <= 1'b1;
      @(posedge sys_clk);
      wr_req <= 1'b0;
      @(posedge sys_clk);
      ack = wr_ack;
   endtask
endmodule

//--- test/counter_diagnostic_record_tb.sv
// self-checking bench of the counter diagnostic record
`timescale 1ns/1ps
module counter_diagnostic_record_tb;
   localparam logic [6:0] KIND = 7'h55; // arbitrary value

   typedef struct {
      logic [2:0] lv;
      logic [7:0] idx;
      logic [7:0] exp;
   } cdr_row_t;

   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        module_failure = 1'b0;
   logic        external_error = 1'b0;
   logic        output_overload = 1'b0;
   logic        diag_buffer_overflow = 1'b0;
   logic [4:0]  lost_event = 5'h00;
   logic        rd_req;
   logic [7:0]  rd_index;
   logic        wr_req;
   logic [7:0]  rd_data;
   logic        rd_ack;
   logic        wr_ack;
   logic        diag_active;
   logic [31:0] s1;
   logic [31:0] s2;
   logic        a;
   int          fails = 0;
   int          check_count = 0;
   int          cyc = 0;
   int          t0;

   // levels: bit 0 failure, bit 1 external error, bit 2 overload
   cdr_row_t rows [20] = '{
      '{3'b000, 8'h02, 8'h00}, '{3'b001, 8'h02, 8'h01}, '{3'b010, 8'h02, 8'h04},
      '{3'b100, 8'h02, 8'h10}, '{3'b111, 8'h02, 8'h15}, '{3'b111, 8'h03, 8'h18},
      '{3'b000, 8'h03, 8'h18}, '{3'b000, 8'h04, 8'h00}, '{3'b000, 8'h05, 8'h00},
      '{3'b000, 8'h06, {1'b0, KIND}}, '{3'b000, 8'h07, 8'h08}, '{3'b000, 8'h08, 8'h01},
      '{3'b000, 8'h09, 8'h00}, '{3'b000, 8'h0a, 8'h00}, '{3'b000, 8'h0b, 8'h00},
      '{3'b000, 8'h11, 8'h00}, '{3'b000, 8'h12, 8'h00}, '{3'b000, 8'h00, 8'h00},
      '{3'b000, 8'hff, 8'h00}, '{3'b111, 8'h0a, 8'h00}
   };

   always #12.5 sys_clk = ~sys_clk;

   always @(posedge sys_clk) cyc <= cyc + 1;

   cdr_top #(.CHANNEL_KIND_CODE(KIND)) u_cdr_top (
      .sys_clk              (sys_clk),
      .reset_n              (reset_n),
      .module_failure       (module_failure),
      .external_error       (external_error),
      .output_overload      (output_overload),
      .diag_buffer_overflow (diag_buffer_overflow),
      .lost_event           (lost_event),
      .rd_req               (rd_req),
      .rd_index             (rd_index),
      .wr_req               (wr_req),
      .rd_data              (rd_data),
      .rd_ack               (rd_ack),
      .wr_ack               (wr_ack),
      .diag_active          (diag_active)
   );

   cdr_host u_cdr_host (
      .sys_clk  (sys_clk),
      .rd_data  (rd_data),
      .rd_ack   (rd_ack),
      .wr_ack   (wr_ack),
      .rd_req   (rd_req),
      .rd_index (rd_index),
      .wr_req   (wr_req)
   );

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t byte read %h, wanted %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t flag read %b, wanted %b", $time, got, exp);
      end
   endtask

   task automatic expect_byte(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] d;
      logic       k;
      u_cdr_host.read_byte(idx, d, k);
      check_bit(k, 1'b1);
      check_byte(d, exp);
   endtask

   task automatic read_stamp(output logic [31:0] s);
      logic [7:0] d;
      logic       k;
      s = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         u_cdr_host.read_byte(8'(8'h13 + i), d, k);
         s = {s[23:0], d};
      end
   endtask

   task automatic pulse_lost(input logic [4:0] v);
      @(posedge sys_clk);
      lost_event <= v;
      @(posedge sys_clk);
      lost_event <= 5'h00;
   endtask

   task automatic test_done(input string name);
      $display("test %s finished, %0d mismatches so far", name, fails);
   endtask

   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      #(25 * 20000);
      fails++;
      $display("[ERR] %0t run did not finish in time", $time);
      end_of_test();
   end

   initial begin
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      foreach (rows[i]) begin
         @(posedge sys_clk);
         {output_overload, external_error, module_failure} <= rows[i].lv;
         repeat (3) @(posedge sys_clk);
         #1;
         check_bit(diag_active, |rows[i].lv);
         expect_byte(rows[i].idx, rows[i].exp);
      end
      @(posedge sys_clk);
      {output_overload, external_error, module_failure} <= 3'b000;
      repeat (3) @(posedge sys_clk);
      test_done("record table");

      for (int b = 0; b < 5; b++) begin
         pulse_lost(5'(1 << b));
         @(posedge sys_clk);
         #1;
         check_bit(diag_active, 1'b1);
         pulse_lost(5'(1 << ((b + 1) % 5)));
         expect_byte(8'h0a, {3'h0, 5'(1 << b)});
         expect_byte(8'h09, 8'h01);
         expect_byte(8'h02, 8'h08);
         expect_byte(8'h05, 8'h40);
         expect_byte(8'h05, 8'h00);
         expect_byte(8'h0a, 8'h00);
         repeat (2) @(posedge sys_clk);
         #1;
         check_bit(diag_active, 1'b0);
      end
      test_done("lost interrupt causes");

      @(posedge sys_clk);
      diag_buffer_overflow <= 1'b1;
      @(posedge sys_clk);
      diag_buffer_overflow <= 1'b0;
      expect_byte(8'h05, 8'h08);
      expect_byte(8'h05, 8'h00);
      expect_byte(8'h0a, 8'h00);
      // overflow in the same cycle as the clearing read must stay set
      fork
         u_cdr_host.read_byte(8'h05, s1[7:0], a);
         begin
            @(posedge sys_clk);
            diag_buffer_overflow <= 1'b1;
            @(posedge sys_clk);
            diag_buffer_overflow <= 1'b0;
         end
      join
      check_bit(a, 1'b1);
      check_byte(s1[7:0], 8'h00);
      expect_byte(8'h05, 8'h08);
      expect_byte(8'h05, 8'h00);
      test_done("buffer overflow");

      u_cdr_host.write_byte(a);
      check_bit(a, 1'b1);
      expect_byte(8'h07, 8'h08);
      expect_byte(8'h03, 8'h18);
      test_done("write ignored");

      // two entries exactly 400 cycles apart must stamp ten ticks apart
      @(posedge sys_clk);
      t0 = cyc;
      pulse_lost(5'h04);
      read_stamp(s1);
      expect_byte(8'h05, 8'h40);
      while (cyc != t0 + 400) @(posedge sys_clk);
      pulse_lost(5'h08);
      read_stamp(s2);
      check_byte(8'(s2 - s1), 8'h0a);
      check_byte(s2[31:24], s1[31:24]);
      expect_byte(8'h05, 8'h40);
      test_done("timestamp spacing");

      pulse_lost(5'h10);
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
      check_bit(diag_active, 1'b0);
      check_bit(rd_ack, 1'b0);
      @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      expect_byte(8'h0a, 8'h00);
      expect_byte(8'h05, 8'h00);
      expect_byte(8'h08, 8'h01);
      // ticker restarted at release; an entry within its first microsecond stamps zero
      pulse_lost(5'h04);
      read_stamp(s1);
      check_bit(s1 == 32'h0000_0000, 1'b1);
      expect_byte(8'h05, 8'h40);
      test_done("reset in mid run");
      end_of_test();
   end
endmodule
